// ### src/dsc_pkg.sv
// Summary of operation
// RULE1 - Only commands with both target select bits zero are decoded, by the command code bits
// RULE2 - Soft power-up code 001001 powers up amplifiers and reference within 8 us
// RULE3 - Effective power-down is hardware power-down input OR software power-down state
// RULE4 - Soft reset code 001111 returns every register to default; datapath gets a default pulse
// RULE5 - Soft reset takes 135 us to complete
// RULE6 - Code 001100 writes control register when read flag is 0, reads when 1
// RULE7 - Control bit 11 picks power-down output: 1 high impedance (default), 0 load to ground
// RULE8 - Control bit 10 picks reference level 2.5 V or 1.25 V; default set by variant
// RULE9 - Control bit 9 enables amplifier boost; off by default
// RULE10 - Control bit 8 enables internal reference; external reference by default
// RULE11 - Control bit 7 enables monitor routing onto the last output pin; off by default
// RULE12 - Control bit 6 enables thermal protection; over-temperature then powers amplifiers down
// RULE13 - After thermal shutdown, soft power-up restores amplifiers only if over-temperature cleared
// RULE14 - Control bits 4 to 0 enable toggle mode per group; bit 5 ignored
// RULE15 - Toggle bit k covers channels 8k to 8k+7
// RULE16 - Code 001010 takes monitored channel from data bits 11 to 6; rest ignored
// RULE17 - Monitor address equal to a channel number routes that channel to the monitor pin
// RULE18 - Monitor address 63 puts the monitor pin in high impedance
// RULE19 - Host sets monitor enable before issuing any monitor select command
// RULE20 - Code 001000 powers down all channels, keeps registers, refuses register writes meanwhile
// RULE21 - Busy stays active for the whole soft reset or soft power-up sequence
// RULE22 - Control read returns the stored 12-bit value, bit 5 as last written
package dsc_pkg;
   // Command fields
   localparam logic [1:0] SEL_SFR = 2'h0;
   localparam logic [5:0] CMD_NOP = 6'h00;
   localparam logic [5:0] CMD_PWR_DOWN = 6'h08;
   localparam logic [5:0] CMD_PWR_UP = 6'h09;
   localparam logic [5:0] CMD_MON_SEL = 6'h0A;
   localparam logic [5:0] CMD_CTRL = 6'h0C;
   localparam logic [5:0] CMD_SOFT_RST = 6'h0F;
   // Control register layout
   localparam int CTRL_W = 12;
   localparam int PD_OUTPUT_STATE_BIT = 11;
   localparam int REF_LEVEL_BIT = 10;
   localparam int AMP_BOOST_BIT = 9;
   localparam int REF_SOURCE_BIT = 8;
   localparam int MONITOR_ENABLE_BIT = 7;
   localparam int THERMAL_PROTECT_BIT = 6;
   localparam int UNUSED_CFG_BIT = 5;
   localparam logic [11:0] CTRL_RESET = 12'h800;
   // Monitor field and channel layout
   localparam int MON_ADDR_HI = 11;
   localparam int MON_ADDR_LO = 6;
   localparam logic [5:0] MON_HIZ_ADDR = 6'h3F;
   localparam int NUM_CH = 40;
   localparam int GROUP_SIZE = 8;
   localparam int NUM_GROUPS = 5;
   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PWRUP_TIME_NS = 8000;
   localparam int SRST_TIME_NS = 135000;
   localparam int PWRUP_CYCLES = PWRUP_TIME_NS / CLK_PERIOD_NS;
   localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 13;

   // One command word from the interface framing logic
   typedef struct packed {
      logic rd;
      logic [1:0] target_select;
      logic [5:0] command_code_bits;
      logic [11:0] data;
   } dsc_cmd_t;

   // Configuration and status driven to the analog side
   typedef struct packed {
      logic pd_active;
      logic pd_hiz;
      logic amp_on;
      logic ref_level_2v5;
      logic ref_internal;
      logic amp_boost;
      logic monitor_en;
      logic thermal_en;
      logic mon_route;
      logic mon_hiz;
      logic [5:0] mon_sel;
      logic [NUM_CH-1:0] toggle_en;
   } dsc_cfg_t;

   typedef enum logic [1:0] {ST_IDLE, ST_PWRUP, ST_SRST} dsc_state_t;
endpackage

// ### src/dsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // Two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// ### src/dsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl #(
   parameter int unsigned SRST_CYCLES_P = dsc_pkg::SRST_CYCLES,
   parameter logic REF_LEVEL_DEF_P = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Command port from interface framing
   input wire logic cmd_valid_in,
   input wire dsc_pkg::dsc_cmd_t cmd_in,
   // Hardware pins and sensors
   input wire logic hw_pd_in,
   input wire logic over_temp_in,
   // Read-back and status
   output logic busy_n_out,
   output logic rd_valid_out,
   output logic [11:0] rd_data_out,
   output logic regs_default_out,
   // Configuration to the analog side
   output dsc_pkg::dsc_cfg_t cfg_out
);
   import dsc_pkg::*;

   localparam logic [11:0] CTRL_RST = {CTRL_RESET[11], REF_LEVEL_DEF_P, CTRL_RESET[9:0]};
   localparam logic [CNT_W-1:0] PWRUP_LOAD = CNT_W'(PWRUP_CYCLES - 1);
   localparam logic [CNT_W-1:0] SRST_LOAD = CNT_W'(SRST_CYCLES_P - 1);

   dsc_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [11:0] ctrl_q, ctrl_d;
   logic [5:0] mon_q, mon_d;
   logic sw_pd_q, sw_pd_d;
   logic therm_q, therm_d;
   logic busy_n_q, busy_n_d;
   logic rd_valid_q, rd_valid_d;
   logic [11:0] rd_data_q, rd_data_d;
   logic regs_def_q, regs_def_d;
   dsc_cfg_t cfg_q, cfg_d;
   logic [1:0] pins_s;
   logic hw_pd_s;
   logic ot_s;
   logic is_sfr, take, pd_eff;
   logic take_pd, take_pu, take_cw, take_cr, take_mon, take_srst;

   // Pin inputs cross into the clock domain
   dsc_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in({hw_pd_in, over_temp_in}),
      .sync_out(pins_s)
   );
   assign hw_pd_s = pins_s[1];
   assign ot_s = pins_s[0];

   // Command decode; busy refuses every command, power-down refuses writes
   always_comb begin
      is_sfr = cmd_valid_in && (cmd_in.target_select == SEL_SFR); // RULE1
      take = is_sfr && (state_q == ST_IDLE); // RULE21
      pd_eff = hw_pd_s | sw_pd_q; // RULE3
      take_pd = take && !cmd_in.rd && (cmd_in.command_code_bits == CMD_PWR_DOWN); // RULE20
      take_pu = take && !cmd_in.rd && (cmd_in.command_code_bits == CMD_PWR_UP); // RULE2
      take_cw = take && !cmd_in.rd && !pd_eff && (cmd_in.command_code_bits == CMD_CTRL); // RULE6 RULE20
      take_cr = take && cmd_in.rd && (cmd_in.command_code_bits == CMD_CTRL); // RULE6
      take_mon = take && !cmd_in.rd && !pd_eff && (cmd_in.command_code_bits == CMD_MON_SEL); // RULE16
      take_srst = take && !cmd_in.rd && !pd_eff && (cmd_in.command_code_bits == CMD_SOFT_RST);
   end

   // Next-state logic for sequencer, registers and outputs
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ctrl_d = ctrl_q;
      mon_d = mon_q;
      sw_pd_d = sw_pd_q;
      therm_d = therm_q;
      rd_valid_d = 1'b0;
      rd_data_d = rd_data_q;
      regs_def_d = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (take_pd) begin
               sw_pd_d = 1'b1; // RULE20
            end
            if (take_pu) begin
               state_d = ST_PWRUP; // RULE2
               cnt_d = PWRUP_LOAD;
            end
            if (take_cw) begin
               ctrl_d = cmd_in.data; // RULE6 RULE22
            end
            if (take_cr) begin
               rd_valid_d = 1'b1;
               rd_data_d = ctrl_q; // RULE22
            end
            if (take_mon) begin
               mon_d = cmd_in.data[MON_ADDR_HI:MON_ADDR_LO]; // RULE16
            end
            if (take_srst) begin
               state_d = ST_SRST; // RULE5
               cnt_d = SRST_LOAD;
               ctrl_d = CTRL_RST; // RULE4
               mon_d = MON_HIZ_ADDR;
               sw_pd_d = 1'b0;
               therm_d = 1'b0;
               regs_def_d = 1'b1;
            end
         end
         ST_PWRUP: begin
            if (cnt_q == '0) begin
               state_d = ST_IDLE; // RULE2
               sw_pd_d = 1'b0;
               if (!ot_s) begin
                  therm_d = 1'b0; // RULE13
               end
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         ST_SRST: begin
            if (cnt_q == '0) begin
               state_d = ST_IDLE; // RULE5
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // Over-temperature set wins over any clear
      if (ctrl_q[THERMAL_PROTECT_BIT] && ot_s) begin
         therm_d = 1'b1; // RULE12
      end
      busy_n_d = (state_d == ST_IDLE); // RULE21
      cfg_d.pd_active = hw_pd_s | sw_pd_d | therm_d; // RULE3
      cfg_d.pd_hiz = cfg_d.pd_active && ctrl_d[PD_OUTPUT_STATE_BIT]; // RULE7
      cfg_d.amp_on = !cfg_d.pd_active; // RULE12
      cfg_d.ref_level_2v5 = ctrl_d[REF_LEVEL_BIT]; // RULE8
      cfg_d.ref_internal = ctrl_d[REF_SOURCE_BIT]; // RULE10
      cfg_d.amp_boost = ctrl_d[AMP_BOOST_BIT]; // RULE9
      cfg_d.monitor_en = ctrl_d[MONITOR_ENABLE_BIT]; // RULE11
      cfg_d.thermal_en = ctrl_d[THERMAL_PROTECT_BIT];
      cfg_d.mon_sel = mon_d;
      cfg_d.mon_route = ctrl_d[MONITOR_ENABLE_BIT] && (mon_d < NUM_CH); // RULE17
      cfg_d.mon_hiz = ctrl_d[MONITOR_ENABLE_BIT] && (mon_d == MON_HIZ_ADDR); // RULE18
      // Group bit k drives channels 8k to 8k+7; bit 5 drives nothing
      for (int i = 0; i < NUM_CH; i++) begin
         cfg_d.toggle_en[i] = ctrl_d[i / GROUP_SIZE]; // RULE14 RULE15
      end
   end

   // State and output registers
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         ctrl_q <= CTRL_RST;
         mon_q <= MON_HIZ_ADDR;
         sw_pd_q <= 1'b0;
         therm_q <= 1'b0;
         busy_n_q <= 1'b1;
         rd_valid_q <= 1'b0;
         rd_data_q <= '0;
         regs_def_q <= 1'b0;
         cfg_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ctrl_q <= ctrl_d;
         mon_q <= mon_d;
         sw_pd_q <= sw_pd_d;
         therm_q <= therm_d;
         busy_n_q <= busy_n_d;
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
         regs_def_q <= regs_def_d;
         cfg_q <= cfg_d;
      end
   end

   // Ports straight from flops
   assign busy_n_out = busy_n_q;
   assign rd_valid_out = rd_valid_q;
   assign rd_data_out = rd_data_q;
   assign regs_default_out = regs_def_q;
   assign cfg_out = cfg_q;

   // Helper: busy length after a soft reset
   logic [CNT_W-1:0] ast_len_q;
   logic ast_srst_q;
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ast_len_q <= '0;
         ast_srst_q <= 1'b0;
      end else if (take_srst) begin
         ast_len_q <= '0;
         ast_srst_q <= 1'b1;
      end else if (!busy_n_q) begin
         ast_len_q <= ast_len_q + 1'b1;
      end else begin
         ast_srst_q <= 1'b0;
      end
   end

   // Checks
   AST_NON_SFR_IGNORED: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE1
      (cmd_valid_in && cmd_in.target_select != SEL_SFR) |=> $stable(ctrl_q) && $stable(mon_q))
      else $error("non-SFR command changed SFR state");
   AST_PWRUP_DONE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE2
      take_pu |=> !busy_n_out ##[1:320] (busy_n_out && !sw_pd_q))
      else $error("soft power-up not finished within 8 us");
   AST_HW_PD_OR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE3
      (hw_pd_s || sw_pd_d) |=> cfg_out.pd_active && !cfg_out.amp_on)
      else $error("power-down not the OR of hardware and software");
   AST_SRST_DEFAULTS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE4
      take_srst |=> (ctrl_q == CTRL_RST) && regs_default_out && (mon_q == MON_HIZ_ADDR))
      else $error("soft reset did not restore defaults");
   AST_SRST_TIME: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE5
      ($rose(busy_n_out) && ast_srst_q) |-> (ast_len_q == CNT_W'(SRST_CYCLES_P)))
      else $error("soft reset busy length wrong");
   AST_CTRL_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE6
      take_cw |=> (ctrl_q == $past(cmd_in.data)) ##1 (cfg_out.amp_boost == ctrl_q[AMP_BOOST_BIT]))
      else $error("control write not stored");
   AST_CTRL_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE22
      take_cr |=> rd_valid_out && (rd_data_out == $past(ctrl_q))
      ##1 (rd_valid_out == $past(take_cr)))
      else $error("control read returned wrong value");
   AST_PD_STATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE7
      cfg_out.pd_active |-> (cfg_out.pd_hiz == ctrl_q[PD_OUTPUT_STATE_BIT]))
      else $error("power-down output state wrong");
   AST_THERMAL_TRIP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE12
      (ctrl_q[THERMAL_PROTECT_BIT] && ot_s) |=> therm_q ##1 !cfg_out.amp_on)
      else $error("thermal trip did not power down amplifiers");
   AST_HOT_PWRUP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE13
      (state_q == ST_PWRUP && cnt_q == '0 && therm_q && ot_s) |=> therm_q)
      else $error("power-up cleared thermal shutdown while hot");
   AST_TOGGLE_MAP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE15
      ##1 (cfg_out.toggle_en[39:32] == {8{ctrl_q[4]}})
      && (cfg_out.toggle_en[7:0] == {8{ctrl_q[0]}}))
      else $error("toggle group mapping wrong");
   AST_MON_HIZ: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE18
      (ctrl_q[MONITOR_ENABLE_BIT] && mon_q == MON_HIZ_ADDR) |-> cfg_out.mon_hiz && !cfg_out.mon_route)
      else $error("monitor address 63 not high impedance");
   AST_PD_REFUSE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE20
      (is_sfr && sw_pd_q && !cmd_in.rd && cmd_in.command_code_bits == CMD_CTRL) |=> $stable(ctrl_q))
      else $error("register written during power-down");
   AST_BUSY_HELD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // RULE21
      (state_q != ST_IDLE) |-> !busy_n_out)
      else $error("busy released during sequence");

   COV_SRST: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      take_srst ##1 !busy_n_out);
   COV_PWRUP: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sw_pd_q ##1 take_pu);
   COV_MON_ROUTE: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      cfg_out.mon_route);
   COV_THERMAL: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      therm_q && !ot_s && take_pu);
endmodule
`default_nettype wire

// ### verification/dsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_host_model (
   // Clock
   input wire logic clk_sys_in,
   // Command port towards the block
   output logic cmd_valid_out,
   output dsc_pkg::dsc_cmd_t cmd_out
);
   import dsc_pkg::*;

   // Idle command port from time zero
   initial begin
      cmd_valid_out = 1'b0;
      cmd_out = '0;
   end

   // One whole command word per one-cycle pulse, changed at the falling edge
   task automatic send(input logic rd, input logic [1:0] sel, input logic [5:0] code,
                       input logic [11:0] data);
      @(negedge clk_sys_in);
      cmd_out = '{rd: rd, target_select: sel, command_code_bits: code, data: data};
      cmd_valid_out = 1'b1;
      @(negedge clk_sys_in);
      cmd_valid_out = 1'b0;
      // Released word no longer shows the old value
      cmd_out = ~cmd_out;
   endtask
endmodule
`default_nettype wire

// ### verification/dsc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dsc_ctrl_tb_top;
   import dsc_pkg::*;
   localparam int SRST_T = 20;
   localparam logic [11:0] CTRL_DEF = {CTRL_RESET[11], 1'b1, CTRL_RESET[9:0]};
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic cmd_valid;
   dsc_cmd_t cmd;
   logic hw_pd = 1'b0;
   logic over_temp = 1'b0;
   logic busy_n;
   logic rd_valid;
   logic [11:0] rd_data;
   logic regs_def;
   dsc_cfg_t cfg;
   logic [11:0] exp_q[$];
   logic [11:0] d;
   logic [5:0] mon_a[4] = '{6'h00, 6'h17, 6'h27, 6'h3F};
   int n_mismatch = 0;
   int num_checks = 0;
   int i, n, p, b, seed;

   // 40 MHz clock
   always #12.5 clk_sys_in = ~clk_sys_in;

   dsc_host_model host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd));

   dsc_ctrl #(.SRST_CYCLES_P(SRST_T), .REF_LEVEL_DEF_P(1'b1)) dut (
      .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
      .hw_pd_in(hw_pd), .over_temp_in(over_temp), .busy_n_out(busy_n),
      .rd_valid_out(rd_valid), .rd_data_out(rd_data), .regs_default_out(regs_def),
      .cfg_out(cfg));

   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Expected toggle enables: group bit k covers channels 8k to 8k+7
   function automatic logic [NUM_CH-1:0] tog(input logic [4:0] g);
      logic [NUM_CH-1:0] r;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         r[ch] = g[ch / GROUP_SIZE];
      end
      return r;
   endfunction

   task automatic ctrl_rd(input logic [11:0] e);
      exp_q.push_back(e);
      host.send(1'b1, SEL_SFR, CMD_CTRL, 12'h000);
      @(negedge clk_sys_in);
   endtask

   task automatic op(input logic [5:0] code, input logic [11:0] data);
      host.send(1'b0, SEL_SFR, code, data);
      @(negedge clk_sys_in);
   endtask

   // Count busy cycles and default pulses of a running sequence
   task automatic cnt_busy(input logic [5:0] code);
      host.send(1'b0, SEL_SFR, code, 12'h000);
      n = 0;
      p = 0;
      while (busy_n === 1'b0 && n < 1000) begin
         if (regs_def === 1'b1) p++;
         n++;
         @(negedge clk_sys_in);
      end
   endtask

   // Read answers compared against the oldest note
   always @(negedge clk_sys_in) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(1'b0, "unexpected read answer");
         else chk(rd_data === exp_q.pop_front(), "read data");
      end
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end

   initial begin
      seed = 22618;
      repeat (10) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      @(negedge clk_sys_in);
      chk(busy_n === 1'b1 && cfg.mon_sel === MON_HIZ_ADDR && cfg.amp_boost === 1'b0
          && cfg.ref_internal === 1'b0 && cfg.monitor_en === 1'b0, "reset outputs");
      ctrl_rd(CTRL_DEF);
      // Random control words, fields and read-back
      for (i = 0; i < 6; i++) begin
         d = 12'($random(seed));
         op(CMD_CTRL, d);
         chk(cfg.amp_boost === d[9] && cfg.ref_internal === d[8] && cfg.ref_level_2v5 === d[10]
             && cfg.monitor_en === d[7] && cfg.thermal_en === d[6], "control fields");
         chk(cfg.toggle_en === tog(d[4:0]), "toggle groups");
         ctrl_rd(d);
      end
      // Other targets never reach the control register
      for (i = 1; i < 4; i++) host.send(1'b0, 2'(i), CMD_CTRL, ~d);
      ctrl_rd(d);
      // Monitor enabled before any select
      op(CMD_CTRL, 12'h080);
      for (i = 0; i < 4; i++) begin
         op(CMD_MON_SEL, {mon_a[i], 6'($random(seed))});
         chk(cfg.mon_sel === mon_a[i] && cfg.mon_route === (mon_a[i] < 6'h28)
             && cfg.mon_hiz === (mon_a[i] == MON_HIZ_ADDR), "monitor select");
      end
      // Power-down in both output states, writes refused, then power-up
      for (b = 0; b < 2; b++) begin
         op(CMD_CTRL, {b[0], 11'h000});
         op(CMD_PWR_DOWN, 12'h000);
         chk(cfg.pd_active === 1'b1 && cfg.amp_on === 1'b0 && cfg.pd_hiz === b[0], "power-down");
         op(CMD_CTRL, 12'h200);
         ctrl_rd({b[0], 11'h000});
         cnt_busy(CMD_PWR_UP);
         chk(n == PWRUP_CYCLES, "power-up busy length");
         chk(cfg.pd_active === 1'b0 && cfg.amp_on === 1'b1, "power-up");
      end
      // Hardware power-down joins the soft state
      hw_pd = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      chk(cfg.pd_active === 1'b1 && cfg.amp_on === 1'b0, "hardware power-down");
      hw_pd = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      chk(cfg.pd_active === 1'b0, "hardware power-down release");
      // Thermal shutdown and recovery
      op(CMD_CTRL, 12'h040);
      over_temp = 1'b1;
      repeat (3) @(negedge clk_sys_in);
      chk(cfg.pd_active === 1'b1 && cfg.amp_on === 1'b0, "thermal shutdown");
      cnt_busy(CMD_PWR_UP);
      chk(cfg.pd_active === 1'b1, "power-up while hot");
      over_temp = 1'b0;
      repeat (3) @(negedge clk_sys_in);
      chk(cfg.pd_active === 1'b1, "shutdown held");
      cnt_busy(CMD_PWR_UP);
      chk(cfg.pd_active === 1'b0 && cfg.amp_on === 1'b1, "power-up when cool");
      // Soft reset restores defaults
      op(CMD_CTRL, 12'h6FF);
      cnt_busy(CMD_SOFT_RST);
      chk(n == SRST_T, "soft reset busy length");
      chk(p == 1, "one default pulse");
      chk(cfg.mon_sel === MON_HIZ_ADDR && cfg.toggle_en === '0, "defaults after reset");
      ctrl_rd(CTRL_DEF);
      repeat (2) @(negedge clk_sys_in);
      chk(exp_q.size() == 0, "reads answered");
      stop_test();
   end
endmodule
`default_nettype wire
